// File: pmc_pkg.sv
// Package: register map, field layout, reset values and timing for the PHY management block
package pmc_pkg;
	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] PMC_ADDR_STATUS    = 16'h3000;
	localparam logic [15:0] PMC_ADDR_REG_ADDR  = 16'h3008;
	localparam logic [15:0] PMC_ADDR_WDATA_LO  = 16'h300C;
	localparam logic [15:0] PMC_ADDR_WDATA_HI  = 16'h300D;
	localparam logic [15:0] PMC_ADDR_RDATA_LO  = 16'h3010;
	localparam logic [15:0] PMC_ADDR_RDATA_HI  = 16'h3011;
	localparam logic [15:0] PMC_ADDR_ACCESS    = 16'h3014;
	localparam logic [15:0] PMC_ADDR_DIVIDER   = 16'h3018;
	localparam logic [15:0] PMC_ADDR_MODE      = 16'h301C;
	localparam logic [15:0] PMC_ADDR_PWR_RST   = 16'h301D;
	localparam logic [15:0] PMC_ADDR_IRQ_STAT  = 16'h3020;
	localparam logic [15:0] PMC_ADDR_IRQ_MASK  = 16'h3021;

	// ----------------------------------------------------------------
	// Field positions and codes
	// ----------------------------------------------------------------
	localparam int          PMC_ST_CABLE_BIT   = 7;
	localparam int          PMC_CR1_POWER_DOWN_BIT_BIT   = 5;
	localparam int          PMC_CR1_FIXED_BIT  = 6;
	localparam int          PMC_CR1_TE_BIT     = 3;
	localparam int          PMC_CR1_RST_BIT    = 0;
	localparam logic [7:0]  PMC_ACC_WRITE      = 8'h01;
	localparam logic [7:0]  PMC_ACC_READ       = 8'h02;
	localparam logic [7:0]  PMC_DIV_32         = 8'h00;
	localparam logic [7:0]  PMC_DIV_64         = 8'h01;
	localparam int          PMC_IRQ_ACC_DONE   = 0;
	localparam int          PMC_IRQ_LINK_CHG   = 1;
	localparam int          PMC_IRQ_RST_DONE   = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  PMC_RST_DIVIDER    = 8'h01;
	localparam logic [7:0]  PMC_RST_PWR_RST    = 8'h40;
	localparam logic [15:0] PMC_RST_WORD       = 16'h0000;

	// ----------------------------------------------------------------
	// Management frame layout and timing
	// ----------------------------------------------------------------
	localparam logic [6:0]  PMC_FRAME_BITS     = 7'd64;
	localparam logic [6:0]  PMC_TA_FIRST_BIT   = 7'd46;
	localparam logic [6:0]  PMC_RD_FIRST_CNT   = 7'd49;
	localparam int          PMC_CLK_MHZ        = 125;
	localparam int          PMC_PHY_RST_NS     = 1000;
	localparam int          PMC_PHY_RST_CYC    = (PMC_PHY_RST_NS * PMC_CLK_MHZ + 999) / 1000;

	typedef struct packed {
		logic        cable_absent;
		logic        half_duplex;
		logic        speed_10;
		logic        link_up;
	} pmc_pins_t;
endpackage

// File: pmc_phy_mgmt.sv
// PHY management block: status, mode/power control and indirect PHY register access
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module pmc_phy_mgmt
	import pmc_pkg::*;
#(
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	input  wire logic        i_system_clock,
	input  wire logic        i_reset_n,
	input  wire logic        i_clk_en,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_wr_data,
	input  wire logic        i_wr_stb,
	input  wire logic        i_rd_stb,
	output logic      [7:0]  o_rd_data,
	input  wire pmc_pins_t   i_phy_pins,
	input  wire logic        i_phy_lock_flag,
	input  wire logic        i_sys_clock_select,
	input  wire logic        i_mdio,
	output logic             o_mdio,
	output logic             o_mdio_oe,
	output logic             o_mdc,
	output logic      [2:0]  o_phy_mode,
	output logic             o_power_down,
	output logic             o_phy_reset,
	output logic             o_ten_te_enable,
	output logic             o_clk_sel_25mhz,
	output logic             o_irq
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		pmc_pins_t   pins_s1;
		pmc_pins_t   pins_s2;
		logic        mdio_s1;
		logic        mdio_s2;
		logic        link_prev;
		logic [2:0]  sync_fill;
		logic [2:0]  mode;
		logic [4:0]  reg_addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [7:0]  access;
		logic [7:0]  divider;
		logic        fixed_b6;
		logic        power_down_bit;
		logic        te;
		logic        rst;
		logic [7:0]  rst_cnt;
		logic [2:0]  irq_stat;
		logic [2:0]  irq_mask;
		logic [7:0]  bus_rdata;
		logic        busy;
		logic        is_read;
		logic [6:0]  div_cnt;
		logic [6:0]  bit_cnt;
		logic [63:0] shift;
		logic [15:0] capture;
		logic        mdc;
		logic        mdio_o;
		logic        mdio_oe;
		logic        te_out;
		logic        clk25;
		logic        irq;
	} pmc_state_t;

	pmc_state_t state_reg;
	pmc_state_t state_next;

	// Half period of the management clock in system clocks
	function automatic logic [6:0] half_period(input logic [7:0] code);
		if (code == PMC_DIV_32) begin
			return 7'd16;
		end else if (code == PMC_DIV_64) begin
			return 7'd32;
		end
		return 7'd64;
	endfunction

	function automatic logic [7:0] status_byte(input pmc_state_t s);
		return {s.pins_s2.cable_absent, 1'b0, s.mode,
			s.pins_s2.half_duplex, s.pins_s2.speed_10, s.pins_s2.link_up};
	endfunction

	logic wr_ok;
	logic rd_ok;
	assign wr_ok = i_wr_stb && i_clk_en;
	assign rd_ok = i_rd_stb && i_clk_en;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [2:0] events;
		logic       fall;
		logic       rise;
		events     = 3'b000;
		fall       = 1'b0;
		rise       = 1'b0;
		state_next = state_reg;

		// Pin synchronisers; first stage feeds only the second
		state_next.pins_s1   = i_phy_pins;
		state_next.pins_s2   = state_reg.pins_s1;
		state_next.mdio_s1   = i_mdio;
		state_next.mdio_s2   = state_reg.mdio_s1;
		state_next.link_prev = state_reg.pins_s2.link_up;
		state_next.sync_fill = {state_reg.sync_fill[1:0], 1'b1};
		// No link event until the synchroniser holds real pin values, else a false edge follows reset
		if (state_reg.sync_fill[2] && state_reg.link_prev != state_reg.pins_s2.link_up) begin
			events[PMC_IRQ_LINK_CHG] = 1'b1;
		end

		// PHY hardware reset timer
		if (state_reg.rst) begin
			if (state_reg.rst_cnt == 8'(PMC_PHY_RST_CYC - 1)) begin
				state_next.rst     = 1'b0;
				state_next.rst_cnt = 8'h00;
				events[PMC_IRQ_RST_DONE] = 1'b1;
			end else begin
				state_next.rst_cnt = state_reg.rst_cnt + 8'h01;
			end
		end

		// Management clock and frame engine
		if (state_reg.busy) begin
			if (state_reg.div_cnt == half_period(state_reg.divider) - 7'd1) begin
				state_next.div_cnt = 7'd0;
				state_next.mdc     = ~state_reg.mdc;
				fall               = state_reg.mdc;
				rise               = ~state_reg.mdc;
			end else begin
				state_next.div_cnt = state_reg.div_cnt + 7'd1;
			end
		end
		if (fall) begin
			if (state_reg.bit_cnt == PMC_FRAME_BITS) begin
				// Frame over: release the line and finish
				state_next.busy    = 1'b0;
				state_next.mdc     = 1'b0;
				state_next.mdio_oe = 1'b0;
				state_next.access  = 8'h00;
				if (state_reg.is_read) begin
					state_next.rdata = state_reg.capture;
				end
				events[PMC_IRQ_ACC_DONE] = 1'b1;
			end else begin
				state_next.mdio_o  = state_reg.shift[63];
				state_next.shift   = {state_reg.shift[62:0], 1'b1};
				state_next.mdio_oe = !(state_reg.is_read && state_reg.bit_cnt >= PMC_TA_FIRST_BIT);
				state_next.bit_cnt = state_reg.bit_cnt + 7'd1;
			end
		end
		if (rise && state_reg.is_read && state_reg.bit_cnt >= PMC_RD_FIRST_CNT) begin
			state_next.capture = {state_reg.capture[14:0], state_reg.mdio_s2};
		end

		// Register writes
		if (wr_ok) begin
			case (i_addr)
				PMC_ADDR_REG_ADDR: begin
					state_next.reg_addr = i_wr_data[4:0];
				end
				PMC_ADDR_WDATA_LO: begin
					state_next.wdata[7:0] = i_wr_data;
				end
				PMC_ADDR_WDATA_HI: begin
					state_next.wdata[15:8] = i_wr_data;
				end
				PMC_ADDR_ACCESS: begin
					// Ignored while a frame is running
					if (!state_reg.busy && (i_wr_data == PMC_ACC_WRITE || i_wr_data == PMC_ACC_READ)) begin
						state_next.access  = i_wr_data;
						state_next.busy    = 1'b1;
						state_next.is_read = (i_wr_data == PMC_ACC_READ);
						state_next.div_cnt = 7'd0;
						state_next.bit_cnt = 7'd0;
						state_next.mdc     = 1'b0;
						state_next.shift   = {32'hFFFF_FFFF, 2'b01,
							(i_wr_data == PMC_ACC_READ) ? 2'b10 : 2'b01,
							PHY_ADDR, state_reg.reg_addr, 2'b10, state_reg.wdata};
					end
				end
				PMC_ADDR_DIVIDER: begin
					if (!state_reg.busy) begin
						state_next.divider = i_wr_data;
					end
				end
				PMC_ADDR_MODE: begin
					if (!i_phy_lock_flag) begin
						state_next.mode = i_wr_data[2:0];
					end
				end
				PMC_ADDR_PWR_RST: begin
					if (!i_phy_lock_flag) begin
						state_next.fixed_b6 = i_wr_data[PMC_CR1_FIXED_BIT];
						state_next.power_down_bit     = i_wr_data[PMC_CR1_POWER_DOWN_BIT_BIT];
						state_next.te       = i_wr_data[PMC_CR1_TE_BIT];
						if (i_wr_data[PMC_CR1_RST_BIT] && !state_reg.rst) begin
							state_next.rst     = 1'b1;
							state_next.rst_cnt = 8'h00;
						end
					end
				end
				PMC_ADDR_IRQ_STAT: begin
					state_next.irq_stat = state_reg.irq_stat & ~i_wr_data[2:0];
				end
				PMC_ADDR_IRQ_MASK: begin
					state_next.irq_mask = i_wr_data[2:0];
				end
				default: begin
				end
			endcase
		end
		// Set wins over a simultaneous clear
		state_next.irq_stat = state_next.irq_stat | events;

		// Register reads: data in the following cycle only
		state_next.bus_rdata = 8'h00;
		if (rd_ok) begin
			case (i_addr)
				PMC_ADDR_STATUS:   state_next.bus_rdata = status_byte(state_reg);
				PMC_ADDR_REG_ADDR: state_next.bus_rdata = {3'b000, state_reg.reg_addr};
				PMC_ADDR_WDATA_LO: state_next.bus_rdata = state_reg.wdata[7:0];
				PMC_ADDR_WDATA_HI: state_next.bus_rdata = state_reg.wdata[15:8];
				PMC_ADDR_RDATA_LO: state_next.bus_rdata = state_reg.rdata[7:0];
				PMC_ADDR_RDATA_HI: state_next.bus_rdata = state_reg.rdata[15:8];
				PMC_ADDR_ACCESS:   state_next.bus_rdata = state_reg.access;
				PMC_ADDR_DIVIDER:  state_next.bus_rdata = state_reg.divider;
				PMC_ADDR_PWR_RST:  state_next.bus_rdata = {1'b0, state_reg.fixed_b6, state_reg.power_down_bit, 1'b0,
					state_reg.te, 2'b00, state_reg.rst};
				PMC_ADDR_IRQ_STAT: state_next.bus_rdata = {5'b00000, state_reg.irq_stat};
				PMC_ADDR_IRQ_MASK: state_next.bus_rdata = {5'b00000, state_reg.irq_mask};
				default:           state_next.bus_rdata = 8'h00;
			endcase
		end

		// Derived outputs, registered
		state_next.te_out = state_next.te && (state_next.mode == 3'b000);
		state_next.clk25  = state_next.power_down_bit || state_next.rst || i_sys_clock_select;
		state_next.irq    = |(state_next.irq_stat & state_next.irq_mask);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_system_clock) begin
		if (!i_reset_n) begin
			state_reg          <= '0;
			state_reg.divider  <= PMC_RST_DIVIDER;
			state_reg.fixed_b6 <= PMC_RST_PWR_RST[PMC_CR1_FIXED_BIT];
			state_reg.wdata    <= PMC_RST_WORD;
			state_reg.rdata    <= PMC_RST_WORD;
		end else if (i_clk_en) begin
			state_reg <= state_next;
		end
	end

	assign o_rd_data       = state_reg.bus_rdata;
	assign o_mdio          = state_reg.mdio_o;
	assign o_mdio_oe       = state_reg.mdio_oe;
	assign o_mdc           = state_reg.mdc;
	assign o_phy_mode      = state_reg.mode;
	assign o_power_down    = state_reg.power_down_bit;
	assign o_phy_reset     = state_reg.rst;
	assign o_ten_te_enable = state_reg.te_out;
	assign o_clk_sel_25mhz = state_reg.clk25;
	assign o_irq           = state_reg.irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_mode_write;
		wr_ok && i_addr == PMC_ADDR_MODE;
	endsequence
	sequence s_status_read;
		rd_ok && i_addr == PMC_ADDR_STATUS;
	endsequence
	sequence s_ctrl_write;
		wr_ok && i_addr == PMC_ADDR_PWR_RST;
	endsequence

	localparam int RST_LIMIT = PMC_PHY_RST_CYC + 4;

	a_cable_bit: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		s_status_read |=> o_rd_data[PMC_ST_CABLE_BIT] == $past(state_reg.pins_s2.cable_absent))
		else $error("cable bit wrong");
	a_status_mode: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		s_status_read |=> o_rd_data[5:3] == $past(o_phy_mode) && o_rd_data[6] == 1'b0)
		else $error("status mode wrong");
	a_mode_locked: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		s_mode_write and i_phy_lock_flag |=> $stable(o_phy_mode))
		else $error("mode changed while locked");
	a_mode_apply: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		s_mode_write and !i_phy_lock_flag |=> o_phy_mode == $past(i_wr_data[2:0]))
		else $error("mode not applied");
	a_access_clear: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		$fell(state_reg.busy) |-> state_reg.access == 8'h00 && state_reg.irq_stat[PMC_IRQ_ACC_DONE])
		else $error("access code not cleared");
	a_te_gate: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		o_ten_te_enable |-> o_phy_mode == 3'b000)
		else $error("te outside mode 000");
	a_clk_forced: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		(o_power_down || o_phy_reset) |-> o_clk_sel_25mhz)
		else $error("25 MHz not forced");
	a_reset_hold: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		$rose(o_phy_reset) |-> o_phy_reset [*8])
		else $error("phy reset too short");
	a_reset_ends: assert property (@(posedge i_system_clock) disable iff (!i_reset_n || !i_clk_en)
		$rose(o_phy_reset) |-> ##[1:RST_LIMIT] !o_phy_reset)
		else $error("phy reset never ends");
	a_clk_restore: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		$fell(o_phy_reset) |-> o_clk_sel_25mhz == (o_power_down || $past(i_sys_clock_select)))
		else $error("clock not restored after phy reset");
	a_ctrl_locked: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		s_ctrl_write and i_phy_lock_flag |=> $stable(o_power_down) && !$rose(o_phy_reset))
		else $error("power control changed while locked");
	a_mdc_idle: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		!state_reg.busy |-> !o_mdc && !o_mdio_oe)
		else $error("management clock active when idle");
	a_div_range: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		state_reg.busy |-> state_reg.div_cnt < half_period(state_reg.divider))
		else $error("divider count out of range");
	a_write_drive: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		state_reg.busy && !state_reg.is_read && state_reg.bit_cnt != 7'd0 |-> o_mdio_oe)
		else $error("data line not driven in write frame");
	a_read_release: assert property (@(posedge i_system_clock) disable iff (!i_reset_n)
		state_reg.busy && state_reg.is_read && state_reg.bit_cnt > PMC_TA_FIRST_BIT |-> !o_mdio_oe)
		else $error("data line driven during read data");
endmodule

// File: pmc_phy_model.sv
// Behavioural PHY register file answering management frames
`timescale 1ns/1ps
module pmc_phy_model #(
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	input  wire logic i_mdc,
	input  wire logic i_mdio,
	input  wire logic i_host_oe,
	output logic      o_mdio,
	output logic      o_mdio_oe
);
	logic [15:0] regs [32];
	logic [15:0] rd_word;
	logic [31:0] sh;
	int          cnt;

	initial begin
		o_mdio = 1'b1;
		o_mdio_oe = 1'b0;
		cnt = 0;
		sh = '0;
		rd_word = '0;
		foreach (regs[i]) regs[i] = 16'hA5C3 ^ {11'h000, 5'(i)};
	end

	// Host raising its enable marks the first preamble bit
	always @(posedge i_host_oe) cnt = 0;

	always @(posedge i_mdc) begin
		sh = {sh[30:0], i_mdio};
		cnt = cnt + 1;
		if (cnt == 64 && sh[29:28] == 2'b01 && sh[27:23] == PHY_ADDR)
			regs[sh[22:18]] = sh[15:0];
	end

	// Data changes on falling edges so the host samples it settled
	always @(negedge i_mdc) begin
		if (cnt == 47 && sh[12:11] == 2'b10 && sh[10:6] == PHY_ADDR) begin
			rd_word = regs[sh[5:1]];
			o_mdio_oe = 1'b1;
			o_mdio = 1'b0;
		end else if (o_mdio_oe && cnt >= 48 && cnt < 64) begin
			o_mdio = rd_word[63 - cnt];
		end else begin
			o_mdio_oe = 1'b0;
			o_mdio = 1'b1;
		end
	end
endmodule

// File: pmc_phy_mgmt_tb_top.sv
// Self-checking testbench for the PHY management block
`timescale 1ns/1ps
module pmc_phy_mgmt_tb_top
	import pmc_pkg::*;
;
	localparam logic [4:0] PA = 5'h01;
	logic        clk = 0, rst_n = 0, en = 1, ws = 0, rs = 0, lock = 0, csel = 0;
	logic [15:0] addr = '0;
	logic [7:0]  wd = '0, rdv, rd_data, code;
	pmc_pins_t   pins = '0;
	logic        mdo, mdo_oe, mdc, m_out, m_oe, mdio_w, power_down_bit, prst, te, c25, irq;
	logic [2:0]  mode;
	logic [31:0] seed = 71;
	logic [31:0] v;
	logic [4:0]  ra;
	int          fails = 0, num_checks = 0, n;
	logic [15:0] ta [12] = '{PMC_ADDR_STATUS, PMC_ADDR_REG_ADDR, PMC_ADDR_WDATA_LO, PMC_ADDR_WDATA_HI,
		PMC_ADDR_RDATA_LO, PMC_ADDR_RDATA_HI, PMC_ADDR_ACCESS, PMC_ADDR_DIVIDER, PMC_ADDR_MODE,
		PMC_ADDR_PWR_RST, PMC_ADDR_IRQ_STAT, 16'h3004};
	logic [7:0]  tv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, PMC_RST_DIVIDER, 8'h00,
		PMC_RST_PWR_RST, 8'h00, 8'h00};

	always #4 clk = ~clk;
	// Pull-up holds the line high when nobody drives it
	assign mdio_w = mdo_oe ? mdo : (m_oe ? m_out : 1'b1);

	pmc_phy_mgmt #(.PHY_ADDR(PA)) pmc_phy_mgmt_i (.i_system_clock(clk), .i_reset_n(rst_n), .i_clk_en(en),
		.i_addr(addr), .i_wr_data(wd), .i_wr_stb(ws), .i_rd_stb(rs), .o_rd_data(rd_data),
		.i_phy_pins(pins), .i_phy_lock_flag(lock), .i_sys_clock_select(csel), .i_mdio(mdio_w),
		.o_mdio(mdo), .o_mdio_oe(mdo_oe), .o_mdc(mdc), .o_phy_mode(mode), .o_power_down(power_down_bit),
		.o_phy_reset(prst), .o_ten_te_enable(te), .o_clk_sel_25mhz(c25), .o_irq(irq));
	pmc_phy_model #(.PHY_ADDR(PA)) pmc_phy_model_i (.i_mdc(mdc), .i_mdio(mdio_w), .i_host_oe(mdo_oe),
		.o_mdio(m_out), .o_mdio_oe(m_oe));

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function logic [7:0] exp_st(pmc_pins_t p, logic [2:0] m);
		return {p.cable_absent, 1'b0, m, p.half_duplex, p.speed_10, p.link_up};
	endfunction

	function logic [15:0] half(logic [7:0] c);
		return (c == 8'h00) ? 16'd16 : (c == 8'h01) ? 16'd32 : 16'd64;
	endfunction

	task chk(string nm, logic [15:0] e, logic [15:0] s);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wr(logic [15:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		ws <= 1'b1;
		@(posedge clk);
		ws <= 1'b0;
	endtask
	task rd(logic [15:0] a);
		@(posedge clk);
		addr <= a;
		rs <= 1'b1;
		@(posedge clk);
		rs <= 1'b0;
		@(negedge clk);
		rdv = rd_data;
	endtask
	task rc(string nm, logic [15:0] a, logic [7:0] e);
		rd(a);
		chk(nm, {8'h00, e}, {8'h00, rdv});
	endtask
	task settle();
		repeat (3) @(negedge clk);
	endtask
	task acc(logic [7:0] c);
		wr(PMC_ADDR_ACCESS, c);
		n = 0;
		rd(PMC_ADDR_ACCESS);
		while (rdv !== 8'h00 && n < 20000) begin
			rd(PMC_ADDR_ACCESS);
			n++;
		end
		chk("access clear", 16'h0000, {8'h00, rdv});
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		#480000;
		fails++;
		$display("[ERR] watchdog expected finish seen hang");
		stop_test();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		foreach (ta[i]) rc("reset value", ta[i], tv[i]);
		$display("test reset done");
		// ----------------------------------------------------------------
		// Status follows pins, writes ignored
		// ----------------------------------------------------------------
		repeat (6) begin
			v = rnd();
			@(posedge clk);
			pins <= v[3:0];
			wr(PMC_ADDR_STATUS, 8'hFF);
			settle();
			rc("status", PMC_ADDR_STATUS, exp_st(pins, 3'b000));
		end
		$display("test status done");
		// ----------------------------------------------------------------
		// Modes, 10BASE-Te and lock
		// ----------------------------------------------------------------
		for (int m = 0; m < 8; m++) begin
			wr(PMC_ADDR_MODE, 8'(m));
			wr(PMC_ADDR_PWR_RST, 8'h48);
			settle();
			rc("status mode", PMC_ADDR_STATUS, exp_st(pins, 3'(m)));
			chk("mode out", 16'(m), {13'h0, mode});
			chk("te enable", 16'(m == 0), {15'h0, te});
		end
		rc("mode readback", PMC_ADDR_MODE, 8'h00);
		@(posedge clk);
		lock <= 1'b1;
		wr(PMC_ADDR_MODE, 8'h04);
		wr(PMC_ADDR_PWR_RST, 8'h61);
		settle();
		chk("locked mode", 16'h0007, {13'h0, mode});
		chk("locked reset", 16'h0000, {15'h0, prst});
		rc("locked ctrl", PMC_ADDR_PWR_RST, 8'h48);
		@(posedge clk);
		lock <= 1'b0;
		$display("test modes done");
		// ----------------------------------------------------------------
		// Power-down, clock select, PHY reset
		// ----------------------------------------------------------------
		for (int c = 0; c < 2; c++) begin
			@(posedge clk);
			csel <= c[0];
			wr(PMC_ADDR_PWR_RST, 8'h40);
			settle();
			chk("clock select", 16'(c), {15'h0, c25});
			wr(PMC_ADDR_PWR_RST, 8'h60);
			settle();
			chk("power down", 16'h0003, {14'h0, power_down_bit, c25});
		end
		@(posedge clk);
		csel <= 1'b0;
		wr(PMC_ADDR_IRQ_STAT, 8'hFF);
		wr(PMC_ADDR_PWR_RST, 8'h41);
		@(negedge clk);
		chk("reset start", 16'h0001, {15'h0, prst});
		n = 0;
		while (prst === 1'b1 && n < 500) begin
			@(negedge clk);
			n++;
			if (n == 3) chk("reset clock", 16'h0001, {15'h0, c25});
		end
		chk("reset length", 16'h0001, 16'(n >= PMC_PHY_RST_CYC - 1 && n <= PMC_PHY_RST_CYC + 1));
		settle();
		rc("reset self clear", PMC_ADDR_PWR_RST, 8'h40);
		chk("clock restored", 16'h0000, {15'h0, c25});
		rc("irq status", PMC_ADDR_IRQ_STAT, 8'h04);
		chk("irq masked", 16'h0000, {15'h0, irq});
		wr(PMC_ADDR_IRQ_MASK, 8'h04);
		settle();
		chk("irq raised", 16'h0001, {15'h0, irq});
		wr(PMC_ADDR_IRQ_STAT, 8'h04);
		settle();
		chk("irq cleared", 16'h0000, {15'h0, irq});
		$display("test power done");
		// ----------------------------------------------------------------
		// Management frames at two dividers
		// ----------------------------------------------------------------
		wr(PMC_ADDR_DIVIDER, 8'h00);
		rc("divider code", PMC_ADDR_DIVIDER, 8'h00);
		wr(PMC_ADDR_IRQ_MASK, 8'h01);
		for (int d = 0; d < 2; d++) begin
			v = rnd();
			code = (d == 0) ? 8'h01 : (v[31:24] | 8'h02);
			ra = v[20:16];
			wr(PMC_ADDR_DIVIDER, code);
			wr(PMC_ADDR_REG_ADDR, {3'b101, ra});
			wr(PMC_ADDR_WDATA_LO, v[7:0]);
			wr(PMC_ADDR_WDATA_HI, v[15:8]);
			wr(PMC_ADDR_ACCESS, 8'h03);
			rc("bad access code", PMC_ADDR_ACCESS, 8'h00);
			wr(PMC_ADDR_ACCESS, PMC_ACC_WRITE);
			@(posedge mdc);
			n = 0;
			while (mdc === 1'b1 && n < 300) begin
				@(negedge clk);
				n++;
			end
			chk("mdc half period", half(code), 16'(n - 1));
			acc(8'h00);
			chk("phy reg written", v[15:0], pmc_phy_model_i.regs[ra]);
			rc("done irq", PMC_ADDR_IRQ_STAT, 8'h01);
			chk("done irq line", 16'h0001, {15'h0, irq});
			wr(PMC_ADDR_IRQ_STAT, 8'h01);
			pmc_phy_model_i.regs[ra] = ~v[15:0];
			acc(PMC_ACC_READ);
			rc("read low", PMC_ADDR_RDATA_LO, ~v[7:0]);
			rc("read high", PMC_ADDR_RDATA_HI, ~v[15:8]);
			wr(PMC_ADDR_IRQ_STAT, 8'h01);
		end
		@(posedge clk);
		en <= 1'b0;
		wr(PMC_ADDR_DIVIDER, 8'h00);
		@(posedge clk);
		en <= 1'b1;
		rc("frozen divider", PMC_ADDR_DIVIDER, code);
		$display("test frames done");
		// ----------------------------------------------------------------
		// Link change interrupt, then a reset in mid-run with link up
		// ----------------------------------------------------------------
		wr(PMC_ADDR_IRQ_STAT, 8'hFF);
		@(posedge clk);
		pins <= pins ^ 4'h1;
		settle();
		rc("link irq", PMC_ADDR_IRQ_STAT, 8'h02);
		@(posedge clk);
		pins <= 4'h1;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) rc("no false link", PMC_ADDR_IRQ_STAT, 8'h00);
		rc("status after reset", PMC_ADDR_STATUS, exp_st(pins, 3'b000));
		foreach (ta[i]) if (i > 0) rc("mid reset value", ta[i], tv[i]);
		$display("test mid reset done");
		stop_test();
	end
endmodule
